/* File: src/special_event_pkg.sv */
//==============================================================================
//==============================================================================
package special_event_pkg;

	//==========================================================================
	// Sizes
	localparam int ADDR_W     = 32;
	localparam int NUM_SRC    = 32;
	localparam int SRC_W      = 5;
	localparam int LEVEL_W    = 3;
	localparam int PADDR_W    = 12;

	//==========================================================================
	// Register byte offsets
	localparam logic [PADDR_W-1:0] OFS_BUS_CTL   = 12'h000;
	localparam logic [PADDR_W-1:0] OFS_EXC_VEC   = 12'h004;
	localparam logic [PADDR_W-1:0] OFS_DRAM_BASE = 12'h008;
	localparam logic [PADDR_W-1:0] OFS_SAVED_PC  = 12'h00c;
	localparam logic [PADDR_W-1:0] OFS_EV_STAT   = 12'h010;
	localparam logic [PADDR_W-1:0] OFS_EV_MASK   = 12'h014;
	localparam logic [PADDR_W-1:0] OFS_STATE     = 12'h018;
	localparam logic [PADDR_W-1:0] OFS_INT_MASK  = 12'h01c;
	localparam logic [PADDR_W-1:0] OFS_VEC_BASE  = 12'h080;

	//==========================================================================
	// Field positions
	localparam int CTL_SET_BIT    = 0;	// core_reset_set_bit
	localparam int CTL_CLR_BIT    = 1;	// core_reset_clear_bit
	localparam int PSW_TFE_BIT    = 10;	// trap_on_fetch_flag
	localparam int PSW_IEN_BIT    = 9;	// global_interrupt_enable
	localparam int PSW_EN_HI      = 15;
	localparam int PSW_FLAG_HI    = 31;
	localparam int EV_BOOT_BIT    = 0;
	localparam int EV_EXC_BIT     = 1;
	localparam int EV_NMI_BIT     = 2;
	localparam int EV_INT_BIT     = 3;
	localparam int EV_W           = 4;
	localparam logic [LEVEL_W-1:0] NMI_LEVEL = 3'h7;

	//==========================================================================
	// Reset values
	localparam logic [ADDR_W-1:0]  RST_DRAM_BASE = 32'h0000_0000;
	localparam logic [ADDR_W-1:0]  RST_ZERO      = 32'h0000_0000;
	localparam logic [EV_W-1:0]    RST_EV        = 4'h0;
	localparam logic [NUM_SRC-1:0] RST_INT_MASK  = 32'h0000_0000;

	//==========================================================================
	// Types
	typedef enum logic [1:0] {
		BOOT,
		HELD,
		RUN
	} core_state_type;

	typedef enum logic [1:0] {
		EV_NONE,
		EV_EXC,
		EV_NMI,
		EV_INT
	} event_kind_type;

	typedef struct packed {
		logic              taken;
		logic [ADDR_W-1:0] target;
	} jump_info_type;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
	} redirect_type;

	typedef struct packed {
		logic             valid;
		logic [SRC_W-1:0] source;
	} ack_type;

endpackage

/* File: src/special_event_dispatch.sv */
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module special_event_dispatch
	import special_event_pkg::*;
#(
	parameter logic [ADDR_W-1:0] DRAM_BASE_RESET = RST_DRAM_BASE
)
(
	// Clock and hardware reset pin
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	// APB slave
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [PADDR_W-1:0]             paddr,
	input  wire logic [31:0]                    pwdata,
	output logic                                pready,
	output logic [31:0]                         prdata,
	output logic                                pslverr,
	// Branch unit
	input  wire jump_info_type                  jump,
	input  wire logic [31:0]                    processor_status_word,
	output redirect_type                        redirect,
	output logic                                coreReset,
	// Vectored interrupt controller
	input  wire logic [NUM_SRC-1:0]             interrupt_pending_set,
	input  wire logic [NUM_SRC-1:0][LEVEL_W-1:0] sourceLevel,
	output ack_type                             dispatchAck,
	// Event interrupt
	output logic                                irq
);

	//==========================================================================
	// State
	core_state_type               state;
	core_state_type               next_state;
	logic [ADDR_W-1:0]            exception_vector_location;
	logic [ADDR_W-1:0]            dramBase;
	logic [ADDR_W-1:0]            saved_destination_pc;
	logic [NUM_SRC-1:0]           interrupt_mask_set;
	logic [EV_W-1:0]              evStat;
	logic [EV_W-1:0]              evMask;
	logic                         inHandler;
	logic [ADDR_W-1:0]            intVector [NUM_SRC];

	//==========================================================================
	// APB decode
	wire                          access    = psel & penable;
	wire                          wrStrobe  = access & pwrite;
	wire                          rdStrobe  = access & ~pwrite;
	wire                          hitVec    = paddr[PADDR_W-1:7] == OFS_VEC_BASE[PADDR_W-1:7];
	wire [SRC_W-1:0]              vecIndex  = paddr[6:2];
	wire                          hitCtl    = paddr == OFS_BUS_CTL;
	wire                          hitExc    = paddr == OFS_EXC_VEC;
	wire                          hitDram   = paddr == OFS_DRAM_BASE;
	wire                          hitPc     = paddr == OFS_SAVED_PC;
	wire                          hitStat   = paddr == OFS_EV_STAT;
	wire                          hitEvMask = paddr == OFS_EV_MASK;
	wire                          hitState  = paddr == OFS_STATE;
	wire                          hitIntMsk = paddr == OFS_INT_MASK;
	wire                          aligned   = paddr[1:0] == 2'h0;
	wire                          mapped    = aligned & (hitVec | hitCtl | hitExc | hitDram
	                                          | hitPc | hitStat | hitEvMask | hitState
	                                          | hitIntMsk);

	// Zero-wait slave; unmapped or misaligned answers with an error
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	// Read data mux
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (rdStrobe && mapped)
		begin
			if (hitVec)
				prdata = intVector[vecIndex];
			else if (hitExc)
				prdata = exception_vector_location;
			else if (hitDram)
				prdata = dramBase;
			else if (hitPc)
				prdata = saved_destination_pc;
			else if (hitStat)
				prdata = {{(32-EV_W){1'b0}}, evStat};
			else if (hitEvMask)
				prdata = {{(32-EV_W){1'b0}}, evMask};
			else if (hitState)
				prdata = {29'h0000_0000, inHandler, state == HELD, state == BOOT};
			else if (hitIntMsk)
				prdata = interrupt_mask_set;
		end
	end

	//==========================================================================
	// Host core reset control
	wire ctlWrite = wrStrobe & hitCtl & aligned;
	wire setReq   = ctlWrite & pwdata[CTL_SET_BIT];
	wire clrReq   = ctlWrite & pwdata[CTL_CLR_BIT] & ~pwdata[CTL_SET_BIT];

	//==========================================================================
	// Event conditions
	wire [31:0] psw        = processor_status_word;
	wire        excFlags   = (|(psw[6:0] & psw[22:16]))
	                         | (psw[PSW_EN_HI] & psw[PSW_FLAG_HI]);
	wire        excPending = excFlags | psw[PSW_TFE_BIT];
	wire        global_interrupt_enable        = psw[PSW_IEN_BIT];
	wire        jumpNow    = (state == RUN) & jump.taken & ~setReq;

	// Eligible sources: pending, unmasked, and NMI or enabled
	logic [NUM_SRC-1:0] eligible;
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++)
		begin : gen_elig
			assign eligible[g] = interrupt_pending_set[g] & interrupt_mask_set[g]
			                     & ((sourceLevel[g] == NMI_LEVEL) | global_interrupt_enable);
		end
	endgenerate

	// Highest level wins, lower source number breaks ties
	logic               intFound;
	logic [SRC_W-1:0]   intSource;
	logic [LEVEL_W-1:0] intLevel;
	always_comb
	begin
		intFound  = 1'b0;
		intSource = '0;
		intLevel  = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (eligible[i] && (!intFound || sourceLevel[i] >= intLevel))
			begin
				intFound  = 1'b1;
				intSource = SRC_W'(i);
				intLevel  = sourceLevel[i];
			end
		end
	end

	// Priority: exception over interrupt
	event_kind_type eventKind;
	assign eventKind = !jumpNow  ? EV_NONE :
	                   excPending ? EV_EXC :
	                   !intFound  ? EV_NONE :
	                   (intLevel == NMI_LEVEL) ? EV_NMI : EV_INT;

	// Target address for the chosen event
	wire [ADDR_W-1:0] eventAddr = (eventKind == EV_EXC) ? exception_vector_location
	                              : intVector[intSource];

	//==========================================================================
	// Core state machine
	always_comb
	begin
		next_state = state;
		case (state)
			BOOT:    next_state = setReq ? HELD : RUN;
			HELD:    next_state = clrReq ? BOOT : HELD;
			RUN:     next_state = setReq ? HELD : RUN;
			default: next_state = BOOT;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= BOOT;
		else
			state <= next_state;
	end

	assign coreReset = state == HELD;

	//==========================================================================
	// Redirect and save of jump target
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			redirect             <= '0;
			saved_destination_pc <= RST_ZERO;
		end
		else if (state == BOOT && !setReq)
		begin
			redirect.valid <= 1'b1;
			redirect.addr  <= dramBase;
		end
		else if (eventKind != EV_NONE)
		begin
			redirect.valid       <= 1'b1;
			redirect.addr        <= eventAddr;
			saved_destination_pc <= jump.target;
		end
		else
			redirect.valid <= 1'b0;
	end

	// Vector-dispatch acknowledge to the interrupt controller
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dispatchAck <= '0;
		else
		begin
			dispatchAck.valid  <= (eventKind == EV_NMI) | (eventKind == EV_INT);
			dispatchAck.source <= intSource;
		end
	end

	// Handler-running flag; cleared by reset entry or by a jump that takes no event
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			inHandler <= 1'b0;
		else if (state != RUN)
			inHandler <= 1'b0;
		else if (eventKind != EV_NONE)
			inHandler <= 1'b1;
		else if (jumpNow)
			inHandler <= 1'b0;
	end

	//==========================================================================
	// Software registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			exception_vector_location <= RST_ZERO;
			dramBase                  <= DRAM_BASE_RESET;
			interrupt_mask_set        <= RST_INT_MASK;
			evMask                    <= RST_EV;
		end
		else if (wrStrobe && aligned)
		begin
			if (hitExc)
				exception_vector_location <= pwdata;
			if (hitDram)
				dramBase <= pwdata;
			if (hitIntMsk)
				interrupt_mask_set <= pwdata;
			if (hitEvMask)
				evMask <= pwdata[EV_W-1:0];
		end
	end

	// Interrupt vector table
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NUM_SRC; i++)
				intVector[i] <= RST_ZERO;
		end
		else if (wrStrobe && aligned && hitVec)
			intVector[vecIndex] <= pwdata;
	end

	//==========================================================================
	// Sticky event status, cleared by read; a new event wins
	logic [EV_W-1:0] evSet;
	always_comb
	begin
		evSet              = '0;
		evSet[EV_BOOT_BIT] = (state == BOOT) & ~setReq;
		evSet[EV_EXC_BIT]  = eventKind == EV_EXC;
		evSet[EV_NMI_BIT]  = eventKind == EV_NMI;
		evSet[EV_INT_BIT]  = eventKind == EV_INT;
	end

	wire rdClear = rdStrobe & hitStat & aligned;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			evStat <= RST_EV;
		else
			evStat <= (rdClear ? RST_EV : evStat) | evSet;
	end

	assign irq = |(evStat & evMask);

endmodule

/* File: tb/special_event_checker.sv */
`timescale 1ns/1ps
//==========
// Dispatch checker
module special_event_checker
	import special_event_pkg::*;
#(
	parameter logic [ADDR_W-1:0] DRAM_BASE_RESET = RST_DRAM_BASE
)
(
	// Clock and reset
	input	wire logic				clk,
	input	wire logic				rst_n,
	// Register bus
	input	wire logic				psel,
	input	wire logic				penable,
	input	wire logic				pwrite,
	input	wire logic [PADDR_W-1:0]		paddr,
	input	wire logic [31:0]			pwdata,
	// Core side
	input	wire jump_info_type			jump,
	input	wire logic [31:0]			processor_status_word,
	input	wire redirect_type			redirect,
	input	wire logic				coreReset,
	input	wire logic [NUM_SRC-1:0][LEVEL_W-1:0]	sourceLevel,
	input	wire ack_type				dispatchAck,
	input	wire logic				irq
);
	logic [31:0]		psw;
	logic			excPend;
	logic			wrAcc;
	logic			hostSet;
	logic			armed;
	logic			live;
	logic [LEVEL_W-1:0]	ackLvl;
	// Exception match, host writes, run window
	assign psw = processor_status_word;
	assign excPend = |(psw[6:0] & psw[22:16]) | (psw[15] & psw[31]) | psw[PSW_TFE_BIT];
	assign wrAcc = psel && penable && pwrite;
	assign hostSet = wrAcc && paddr == OFS_BUS_CTL && pwdata[CTL_SET_BIT];
	assign live = armed && !coreReset && !hostSet;
	assign ackLvl = sourceLevel[dispatchAck.source];
	// Armed one edge after the boot redirect
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			armed <= 1'b0;
		else
			armed <= !coreReset && (armed || redirect.valid);
	sequence excJump;
		live && jump.taken && excPend;
	endsequence
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	exc_entry_a: assert property (excJump |=> redirect.valid)
		else $error("exception jump not redirected");
	exc_first_a: assert property (excJump |=> !dispatchAck.valid)
		else $error("interrupt taken over exception");
	jump_only_a: assert property (live && !jump.taken |=> !redirect.valid)
		else $error("redirect without jump");
	ack_cause_a: assert property (dispatchAck.valid |-> redirect.valid && $past(jump.taken))
		else $error("ack without jump redirect");
	held_quiet_a: assert property (coreReset && $past(coreReset) |-> !redirect.valid)
		else $error("redirect while core held");
	boot_vector_a: assert property ($rose(rst_n) |=>
		redirect.valid && redirect.addr == DRAM_BASE_RESET)
		else $error("no boot redirect");
	ack_level_a: assert property (dispatchAck.valid |->
		ackLvl == NMI_LEVEL || $past(psw[PSW_IEN_BIT]))
		else $error("gated interrupt dispatched");
	irq_cause_a: assert property ($rose(irq) |-> redirect.valid || $past(wrAcc))
		else $error("irq rose without cause");
endmodule
bind special_event_dispatch special_event_checker #(.DRAM_BASE_RESET(DRAM_BASE_RESET))
	u_special_event_checker (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .jump(jump),
	.processor_status_word(processor_status_word), .redirect(redirect),
	.coreReset(coreReset), .sourceLevel(sourceLevel), .dispatchAck(dispatchAck), .irq(irq));

/* File: tb/core_side_model.sv */
`timescale 1ns/1ps
//==========
// Pipeline and interrupt controller model
module core_side_model
	import special_event_pkg::*;
(
	// Clock and reset
	input	wire logic			clk,
	input	wire logic			rst_n,
	// Bench commands
	input	wire logic			fire,
	input	wire logic [ADDR_W-1:0]		dest,
	input	wire logic [NUM_SRC-1:0]	raise,
	// Dispatch side
	input	wire ack_type			ack,
	output	jump_info_type			jump,
	output	logic [NUM_SRC-1:0]		pend
);
	// One taken jump per command, target scrambled when idle
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			jump <= '0;
		else
			jump <= '{fire, fire ? dest : ~jump.target};
	// Requests stay until dispatched
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			pend <= '0;
		else
			pend <= (pend | raise) & ~(ack.valid ? 32'h1 << ack.source : 32'h0);
endmodule

/* File: tb/special_event_dispatch_test.sv */
`timescale 1ns/1ps
`define CK(a, b) begin nCompared++; if ((a) !== (b)) begin failCount++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
//==========
// Dispatch bench
module special_event_dispatch_test;
	import special_event_pkg::*;
	localparam logic [31:0] BOOT_AT = 32'h0001_0000;
	logic				clk, rst_n, psel, penable, pwrite, fire, pready;
	logic				pslverr, coreReset, irq, err, run;
	logic [PADDR_W-1:0]		paddr;
	logic [31:0]			pwdata, prdata, psw, dest, raise, pend, mp, im, xv, rd, s;
	logic [31:0]			vec [32];
	logic [NUM_SRC-1:0][LEVEL_W-1:0] lvl;
	jump_info_type			jump;
	redirect_type			redirect;
	ack_type			ack;
	int				failCount, nCompared, best, i, k, e;
	// Design and far side
	special_event_dispatch #(.DRAM_BASE_RESET(BOOT_AT)) u_special_event_dispatch (.clk(clk),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .jump(jump),
		.processor_status_word(psw), .redirect(redirect), .coreReset(coreReset),
		.interrupt_pending_set(pend), .sourceLevel(lvl), .dispatchAck(ack), .irq(irq));
	core_side_model u_core_side_model (.clk(clk), .rst_n(rst_n), .fire(fire), .dest(dest),
		.raise(raise), .ack(ack), .jump(jump), .pend(pend));
	// Clock
	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task results;
		if (failCount == 0 && nCompared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Bounded wait ran out: count it and close the run
	task tmo(input logic ok);
		if (!ok)
		begin
			failCount++;
			$display("[FAIL] %0t wait timed out", $time);
			results;
		end
	endtask
	// One bus transfer, held until the edge that samples ready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic rdy;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		k = 0;
		rdy = 0;
		while (rdy !== 1'b1 && k < 9)
		begin
			@(negedge clk);
			rdy = pready;
			rd = prdata;
			err = pslverr;
			@(posedge clk);
			k++;
		end
		tmo(rdy === 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task boot(input logic [31:0] a);
		k = 0;
		@(negedge clk);
		while (redirect.valid !== 1 && k < 9)
		begin
			@(negedge clk);
			k++;
		end
		tmo(redirect.valid === 1'b1);
		`CK(redirect.addr, a)
		@(posedge clk);
	endtask
	// Jump with model prediction
	task jmp(input logic f, input logic [31:0] tg, input logic [31:0] ps, input logic [31:0] r);
		logic ex;
		logic ev;
		logic ak;
		mp = mp | r;
		ex = |(ps[6:0] & ps[22:16]) | (ps[15] & ps[31]) | ps[10];
		best = -1;
		for (i = 0; i < 32; i++)
			if (mp[i] && im[i] && (lvl[i] == 7 || ps[9]) && (best < 0 || lvl[i] > lvl[best]))
				best = i;
		ev = f && run && (ex || best >= 0);
		ak = ev && !ex;
		fire <= f;
		dest <= tg;
		psw <= ps;
		raise <= r;
		@(posedge clk);
		fire <= 0;
		raise <= 0;
		@(posedge clk);
		@(negedge clk);
		`CK(redirect.valid, ev)
		if (ev) `CK(redirect.addr, ex ? xv : vec[best])
		`CK(ack.valid, ak)
		if (ak) `CK(ack.source, best[4:0])
		if (ak) mp[best] = 0;
		@(posedge clk);
		if (ev) apb(0, OFS_SAVED_PC, 0);
		if (ev) `CK(rd, tg)
	endtask
	initial
	begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, fire, dest, raise, psw, lvl} = '0;
		{failCount, nCompared, mp, im, xv, run} = '0;
		void'($urandom(32'h10aa));
		repeat (2) @(posedge clk);
		rst_n <= 1;
		boot(BOOT_AT);
		run = 1;
		apb(0, OFS_EV_STAT, 0);
		`CK(rd, 32'h1)
		apb(0, OFS_EV_STAT, 0);
		`CK(rd, 32'h0)
		apb(0, 12'h020, 0);
		`CK(err, 1'b1)
		apb(1, OFS_SAVED_PC, 32'h5);
		apb(0, OFS_SAVED_PC, 0);
		`CK(rd, RST_ZERO)
		xv = $urandom;
		apb(1, OFS_EXC_VEC, xv);
		for (e = 0; e < 32; e++)
		begin
			vec[e] = $urandom;
			lvl[e] <= 3'($urandom);
			apb(1, OFS_VEC_BASE + 12'(4 * e), vec[e]);
		end
		im = $urandom | 32'h1;
		lvl[0] <= NMI_LEVEL;
		apb(1, OFS_INT_MASK, im);
		repeat (80)
		begin
			e = $urandom % 5;
			s = ($urandom & 32'h200) | (e == 0 ? 32'h400 : e == 1 ? 32'h8_0008 :
				e == 2 ? 32'h8000_8000 : 32'h0);
			jmp($urandom % 4 != 0, $urandom, s, $urandom & $urandom & $urandom);
		end
		apb(0, OFS_EV_STAT, 0);
		apb(1, OFS_EV_MASK, 32'h2);
		jmp(1, 32'h40, 32'h400, 32'h0);
		apb(0, OFS_STATE, 0);
		`CK(rd, 32'h4)
		`CK(irq, 1'b1)
		apb(0, OFS_EV_STAT, 0);
		`CK(rd[EV_EXC_BIT], 1'b1)
		`CK(irq, 1'b0)
		jmp(1, 32'h44, 32'h0, 32'h1);
		`CK(irq, 1'b0)
		apb(1, OFS_DRAM_BASE, 32'h0002_0000);
		apb(1, OFS_BUS_CTL, 32'h1);
		`CK(coreReset, 1'b1)
		run = 0;
		jmp(1, 32'h48, 32'h400, 32'h0);
		apb(1, OFS_BUS_CTL, 32'h2);
		`CK(coreReset, 1'b0)
		boot(32'h0002_0000);
		fire <= 1;
		rst_n <= 0;
		@(posedge clk);
		fire <= 0;
		@(posedge clk);
		rst_n <= 1;
		boot(BOOT_AT);
		apb(0, OFS_DRAM_BASE, 0);
		`CK(rd, BOOT_AT)
		results;
	end
endmodule
